// [rtl/lpcs_regs.vh]
// Offsets, field positions, reset values and interval counts for the
// low-power calibration scheduler.
// Assumes inclusion by bare name from the scheduler design files.
`ifndef LPCS_REGS_VH
`define LPCS_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LPCS_IDX_PIN_CFG 10'h06b
`define LPCS_IDX_SOFT_TRIG 10'h06c
`define LPCS_IDX_LP_CTRL 10'h06e
`define LPCS_IDX_GAIN 10'h07a
`define LPCS_IDX_BG_CTRL 10'h100
`define LPCS_IDX_STATUS 10'h101

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPCS_RST_SOFT_TRIG 8'h01
`define LPCS_RST_LP_CTRL 8'h88
`define LPCS_RST_GAIN 8'h00
`define LPCS_RST_PIN_CFG 1'h0
`define LPCS_RST_BG_CTRL 1'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LPCS_SOFT_TRIG_BIT 0
`define LPCS_SRC_SEL_BIT 0
`define LPCS_BG_EN_BIT 0
`define LPCS_LOW_POWER_CAL_ENABLE_BIT 0
`define LPCS_TRIGGERED_SLEEP_MODE_BIT 1
`define LPCS_WAKE_LSB 3
`define LPCS_WAKE_MSB 4
`define LPCS_SLEEP_LSB 5
`define LPCS_SLEEP_MSB 7

// ----------------------------------------------------------------------
// Interval lengths in sample-clock periods
// ----------------------------------------------------------------------
`define LPCS_CNT_W 41
`define LPCS_SLEEP_CNT0 41'd1152
`define LPCS_SLEEP_CNT1 41'd4194432
`define LPCS_SLEEP_CNT2 41'd33554560
`define LPCS_SLEEP_CNT3 41'd268435584
`define LPCS_SLEEP_CNT4 41'd2147483776
`define LPCS_SLEEP_CNT5 41'd17179869312
`define LPCS_SLEEP_CNT6 41'd137438953600
`define LPCS_SLEEP_CNT7 41'd1099511627904
`define LPCS_SETTLE_CNT0 41'd1152
`define LPCS_SETTLE_CNT1 41'd33554560
`define LPCS_SETTLE_CNT2 41'd268435584
`define LPCS_SETTLE_CNT3 41'd2147483776

`endif

// [rtl/lpcs_sample_tick.v]
// Sample-clock enable divider for the low-power calibration scheduler.
// Assumes mclk is the only clock; the sample rate is mclk divided by DIV.
`timescale 1ns/10ps

module lpcs_sample_tick
#(
   parameter DIV = 1
)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Sample-period enable
   output reg sampleTick
);

   reg [15:0] divCount;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         divCount <= 16'h0000;
         sampleTick <= 1'b0;
      end
      else if (divCount >= DIV[15:0] - 16'h0001)
      begin
         divCount <= 16'h0000;
         sampleTick <= 1'b1;
      end
      else
      begin
         divCount <= divCount + 16'h0001;
         sampleTick <= 1'b0;
      end
   end

endmodule // lpcs_sample_tick

// [rtl/lpcs_interval_timer.v]
// Down counter of sample-clock periods for sleep and settling intervals.
// Assumes a one-cycle start pulse with the length valid in that cycle.
`timescale 1ns/10ps
`include "lpcs_regs.vh"

module lpcs_interval_timer
#(
   parameter CW = `LPCS_CNT_W
)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Control
   input wire sampleTick,
   input wire start,
   input wire stop,
   input wire [CW-1:0] length,
   // Result
   output reg busy,
   output reg done
);

   reg [CW-1:0] remaining;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         remaining <= {CW{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (stop)
      begin
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (start)
      begin
         // A fresh phase always restarts the count from the full length
         remaining <= length;
         busy <= 1'b1;
         done <= 1'b0;
      end
      else if (busy && sampleTick)
      begin
         if (remaining <= {{(CW-1){1'b0}}, 1'b1})
         begin
            busy <= 1'b0;
            done <= 1'b1;
         end
         else
         begin
            remaining <= remaining - {{(CW-1){1'b0}}, 1'b1};
            done <= 1'b0;
         end
      end
      else
      begin
         done <= 1'b0;
      end
   end

endmodule // lpcs_interval_timer

// [rtl/lpcs_scheduler.v]
// Low-power background calibration scheduler with APB register slave.
// Assumes an APB master on mclk; the calibration engine answers
// calibrateCore with coreCalDone.
`timescale 1ns/10ps
`include "lpcs_regs.vh"

module lpcs_scheduler
#(
   parameter SAMPLE_DIV = 1,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT0 = `LPCS_SLEEP_CNT0,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT1 = `LPCS_SLEEP_CNT1,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT2 = `LPCS_SLEEP_CNT2,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT3 = `LPCS_SLEEP_CNT3,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT4 = `LPCS_SLEEP_CNT4,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT5 = `LPCS_SLEEP_CNT5,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT6 = `LPCS_SLEEP_CNT6,
   parameter [`LPCS_CNT_W-1:0] SLEEP_CNT7 = `LPCS_SLEEP_CNT7,
   parameter [`LPCS_CNT_W-1:0] SETTLE_CNT0 = `LPCS_SETTLE_CNT0,
   parameter [`LPCS_CNT_W-1:0] SETTLE_CNT1 = `LPCS_SETTLE_CNT1,
   parameter [`LPCS_CNT_W-1:0] SETTLE_CNT2 = `LPCS_SETTLE_CNT2,
   parameter [`LPCS_CNT_W-1:0] SETTLE_CNT3 = `LPCS_SETTLE_CNT3
)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Calibration trigger pin
   input wire calTriggerPin,
   // Calibration engine handshake
   input wire coreCalDone,
   output reg calibrateCore,
   // Converter core control
   output reg coreSleep,
   output reg calTriggerLevel,
   output reg [7:0] gainTrim
);

   localparam CW = `LPCS_CNT_W;

   // ------------------------------------------------------------------
   // Scheduler states
   // ------------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SLEEP = 2'b01;
   localparam [1:0] ST_SETTLE = 2'b10;
   localparam [1:0] ST_CAL = 2'b11;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   reg [7:0] softTrigger;
   reg [7:0] lpCalControl;
   reg triggerSourceSelect;
   reg backgroundCalEnable;
   reg [1:0] state;
   reg [1:0] next_state;
   reg next_coreSleep;
   reg next_calibrateCore;
   reg timerStart;
   reg timerStop;
   reg [CW-1:0] timerLength;
   reg [31:0] readValue;
   reg readHit;
   wire sampleTick;
   wire timerBusy;
   wire timerDone;
   wire lowPowerActive;
   wire triggeredSleepMode;
   wire selectedTrigger;
   wire [2:0] sleepIntervalCode;
   wire [1:0] settlingIntervalCode;
   wire setupPhase;
   wire accessDone;
   wire [9:0] regIndex;

   // ------------------------------------------------------------------
   // Code decoding
   // ------------------------------------------------------------------
   function [CW-1:0] sleepLength;
      input [2:0] code;
      begin
         case (code)
            3'h0: sleepLength = SLEEP_CNT0;
            3'h1: sleepLength = SLEEP_CNT1;
            3'h2: sleepLength = SLEEP_CNT2;
            3'h3: sleepLength = SLEEP_CNT3;
            3'h4: sleepLength = SLEEP_CNT4;
            3'h5: sleepLength = SLEEP_CNT5;
            3'h6: sleepLength = SLEEP_CNT6;
            default: sleepLength = SLEEP_CNT7;
         endcase
      end
   endfunction

   function [CW-1:0] settleLength;
      input [1:0] code;
      begin
         case (code)
            2'h0: settleLength = SETTLE_CNT0;
            2'h1: settleLength = SETTLE_CNT1;
            2'h2: settleLength = SETTLE_CNT2;
            default: settleLength = SETTLE_CNT3;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------
   // Field extraction and trigger source
   // ------------------------------------------------------------------
   assign sleepIntervalCode = lpCalControl[`LPCS_SLEEP_MSB:`LPCS_SLEEP_LSB];
   assign settlingIntervalCode = lpCalControl[`LPCS_WAKE_MSB:`LPCS_WAKE_LSB];
   assign triggeredSleepMode = lpCalControl[`LPCS_TRIGGERED_SLEEP_MODE_BIT];
   // Low-power enable counts only under background calibration
   assign lowPowerActive = lpCalControl[`LPCS_LOW_POWER_CAL_ENABLE_BIT] & backgroundCalEnable;
   assign selectedTrigger = triggerSourceSelect ? calTriggerPin
      : softTrigger[`LPCS_SOFT_TRIG_BIT];

   // ------------------------------------------------------------------
   // Sample-period enable and interval timer
   // ------------------------------------------------------------------
   lpcs_sample_tick #(
      .DIV(SAMPLE_DIV)
   ) uTick (
      .mclk(mclk),
      .rst_n(rst_n),
      .sampleTick(sampleTick)
   );

   lpcs_interval_timer #(
      .CW(CW)
   ) uTimer (
      .mclk(mclk),
      .rst_n(rst_n),
      .sampleTick(sampleTick),
      .start(timerStart),
      .stop(timerStop),
      .length(timerLength),
      .busy(timerBusy),
      .done(timerDone)
   );

   // ------------------------------------------------------------------
   // Sleep, settle and calibrate sequencing
   // ------------------------------------------------------------------
   always @*
   begin
      next_state = state;
      next_coreSleep = coreSleep;
      next_calibrateCore = calibrateCore;
      timerStart = 1'b0;
      timerStop = 1'b0;
      timerLength = sleepLength(sleepIntervalCode);
      case (state)
         ST_IDLE:
         begin
            if (lowPowerActive)
            begin
               next_state = ST_SLEEP;
               next_coreSleep = 1'b1;
               timerStart = 1'b1;
            end
         end
         ST_SLEEP:
         begin
            if (!lowPowerActive)
            begin
               next_state = ST_IDLE;
               next_coreSleep = 1'b0;
               timerStop = 1'b1;
            end
            else if (triggeredSleepMode)
            begin
               // Timer held at its start so a later switch to autonomous
               // begins a full interval
               timerStart = 1'b1;
               if (!selectedTrigger)
               begin
                  next_state = ST_SETTLE;
                  next_coreSleep = 1'b0;
                  timerLength = settleLength(settlingIntervalCode);
               end
            end
            else if (timerDone)
            begin
               next_state = ST_SETTLE;
               next_coreSleep = 1'b0;
               timerStart = 1'b1;
               timerLength = settleLength(settlingIntervalCode);
            end
            else if (!timerBusy)
            begin
               timerStart = 1'b1;
            end
         end
         ST_SETTLE:
         begin
            if (!lowPowerActive)
            begin
               next_state = ST_IDLE;
               timerStop = 1'b1;
            end
            else if (timerDone)
            begin
               next_state = ST_CAL;
               next_calibrateCore = 1'b1;
            end
         end
         ST_CAL:
         begin
            if (!lowPowerActive)
            begin
               next_state = ST_IDLE;
               next_calibrateCore = 1'b0;
            end
            else if (coreCalDone)
            begin
               next_state = ST_SLEEP;
               next_calibrateCore = 1'b0;
               next_coreSleep = 1'b1;
               timerStart = 1'b1;
            end
         end
         default:
         begin
            next_state = ST_IDLE;
            next_coreSleep = 1'b0;
            next_calibrateCore = 1'b0;
            timerStop = 1'b1;
         end
      endcase
   end

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         coreSleep <= 1'b0;
         calibrateCore <= 1'b0;
         calTriggerLevel <= 1'b0;
      end
      else
      begin
         state <= next_state;
         coreSleep <= next_coreSleep;
         calibrateCore <= next_calibrateCore;
         calTriggerLevel <= selectedTrigger;
      end
   end

   // ------------------------------------------------------------------
   // APB access: one-cycle access phase, no wait states
   // ------------------------------------------------------------------
   assign regIndex = paddr[11:2];
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;

   always @*
   begin
      readHit = 1'b1;
      readValue = 32'h00000000;
      case (regIndex)
         `LPCS_IDX_PIN_CFG: readValue[`LPCS_SRC_SEL_BIT] = triggerSourceSelect;
         `LPCS_IDX_SOFT_TRIG: readValue[7:0] = softTrigger;
         `LPCS_IDX_LP_CTRL: readValue[7:0] = lpCalControl;
         `LPCS_IDX_GAIN: readValue[7:0] = gainTrim;
         `LPCS_IDX_BG_CTRL: readValue[`LPCS_BG_EN_BIT] = backgroundCalEnable;
         `LPCS_IDX_STATUS: readValue[5:0] = {lowPowerActive, calTriggerLevel,
            calibrateCore, coreSleep, state};
         default: readHit = 1'b0;
      endcase
   end

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (setupPhase)
      begin
         pready <= 1'b1;
         pslverr <= ~readHit;
         prdata <= (pwrite || !readHit) ? 32'h00000000 : readValue;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         softTrigger <= `LPCS_RST_SOFT_TRIG;
         lpCalControl <= `LPCS_RST_LP_CTRL;
         gainTrim <= `LPCS_RST_GAIN;
         triggerSourceSelect <= `LPCS_RST_PIN_CFG;
         backgroundCalEnable <= `LPCS_RST_BG_CTRL;
      end
      else if (accessDone && pwrite)
      begin
         case (regIndex)
            `LPCS_IDX_PIN_CFG: triggerSourceSelect <= pwdata[`LPCS_SRC_SEL_BIT];
            `LPCS_IDX_SOFT_TRIG: softTrigger <= pwdata[7:0];
            `LPCS_IDX_LP_CTRL: lpCalControl <= pwdata[7:0];
            `LPCS_IDX_GAIN: gainTrim <= pwdata[7:0];
            `LPCS_IDX_BG_CTRL: backgroundCalEnable <= pwdata[`LPCS_BG_EN_BIT];
            default: gainTrim <= gainTrim;
         endcase
      end
   end

endmodule // lpcs_scheduler

// [verif/lpcs_scheduler_asserts.sv]
// Checker for the low-power calibration scheduler, bound to its top.
// Assumes mapped APB writes land at the edge where pready is high.
`timescale 1ns/10ps
`include "lpcs_regs.vh"

module lpcs_scheduler_asserts
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Trigger, engine and core control
   input wire calTriggerPin,
   input wire coreCalDone,
   input wire calibrateCore,
   input wire coreSleep,
   input wire calTriggerLevel,
   input wire [7:0] gainTrim
);
   // ------
   // Register shadows
   // ------
   reg srcSel, softBit, bgEn;
   reg [7:0] lpCtl;
   wire wrEn = psel && penable && pwrite && pready;
   wire active = lpCtl[0] && bgEn;
   wire trigOn = active && lpCtl[1];
   wire trigSel = srcSel ? calTriggerPin : softBit;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         srcSel <= 1'b0;
         softBit <= 1'b1;
         bgEn <= 1'b0;
         lpCtl <= 8'h88;
      end
      else if (wrEn)
      begin
         if (paddr[11:2] == `LPCS_IDX_PIN_CFG)
            srcSel <= pwdata[0];
         if (paddr[11:2] == `LPCS_IDX_SOFT_TRIG)
            softBit <= pwdata[0];
         if (paddr[11:2] == `LPCS_IDX_BG_CTRL)
            bgEn <= pwdata[0];
         if (paddr[11:2] == `LPCS_IDX_LP_CTRL)
            lpCtl <= pwdata[7:0];
      end
   end

   // ------
   // Properties
   // ------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_trigSel;
      $past(rst_n) |-> calTriggerLevel == $past(trigSel);
   endproperty
   a_trigSel: assert property (p_trigSel)
      else $error("trigger level mismatch");
   property p_softRst;
      $rose(rst_n) |=> calTriggerLevel;
   endproperty
   a_softRst: assert property (p_softRst)
      else $error("trigger level not high after reset");
   property p_gain;
      wrEn && paddr[11:2] == `LPCS_IDX_GAIN |=> gainTrim == $past(pwdata[7:0]);
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain trim not updated");
   property p_idle;
      !active |=> !coreSleep && !calibrateCore;
   endproperty
   a_idle: assert property (p_idle)
      else $error("core control active while disabled");
   property p_enter;
      $rose(active) |-> ##[1:2] coreSleep;
   endproperty
   a_enter: assert property (p_enter)
      else $error("core did not go to sleep");
   property p_trigWake;
      trigOn && coreSleep && !trigSel |-> ##[1:2] !coreSleep;
   endproperty
   a_trigWake: assert property (p_trigWake)
      else $error("core not woken by low trigger");
   property p_trigHold;
      trigOn && $past(trigOn) && trigSel && $past(trigSel) && $past(trigSel, 2) && coreSleep
         |=> coreSleep;
   endproperty
   a_trigHold: assert property (p_trigHold)
      else $error("core woke while trigger high");
   property p_calHold;
      active && calibrateCore && !coreCalDone |=> calibrateCore;
   endproperty
   a_calHold: assert property (p_calHold)
      else $error("calibrate request dropped early");
   property p_calDone;
      active && calibrateCore && coreCalDone |=> !calibrateCore && coreSleep;
   endproperty
   a_calDone: assert property (p_calDone)
      else $error("no return to sleep after calibration");
   property p_calAwake;
      calibrateCore |-> !coreSleep;
   endproperty
   a_calAwake: assert property (p_calAwake)
      else $error("calibrating a sleeping core");
endmodule // lpcs_scheduler_asserts

bind lpcs_scheduler lpcs_scheduler_asserts chk_u (
   .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .calTriggerPin(calTriggerPin), .coreCalDone(coreCalDone),
   .calibrateCore(calibrateCore), .coreSleep(coreSleep),
   .calTriggerLevel(calTriggerLevel), .gainTrim(gainTrim)
);

// [verif/tb_lpcs_scheduler.sv]
// Self-checking bench for the low-power calibration scheduler.
// Assumes the rtl files and the bound checker; mclk is 40 MHz.
`timescale 1ns/10ps
`include "lpcs_regs.vh"

module tb_lpcs_scheduler;
   // ------
   // Signals
   // ------
   reg mclk, rst_n, psel, penable, pwrite, calTriggerPin, coreCalDone, e;
   reg [11:0] paddr;
   reg [31:0] pwdata, r;
   wire [31:0] prdata;
   wire pready, pslverr, calibrateCore, coreSleep, calTriggerLevel;
   wire [7:0] gainTrim;
   integer miscompares, checks, i, n;
   localparam [11:0] aSrc = {`LPCS_IDX_PIN_CFG, 2'b00};
   localparam [11:0] aSoft = {`LPCS_IDX_SOFT_TRIG, 2'b00};
   localparam [11:0] aLp = {`LPCS_IDX_LP_CTRL, 2'b00};
   localparam [11:0] aGain = {`LPCS_IDX_GAIN, 2'b00};
   localparam [11:0] aBg = {`LPCS_IDX_BG_CTRL, 2'b00};

   localparam [11:0] aStat = {`LPCS_IDX_STATUS, 2'b00};
   // Codes 0 keep their own length; five codes are shortened so they can be timed in full
   localparam [40:0] slp0 = `LPCS_SLEEP_CNT0;
   localparam [40:0] stl0 = `LPCS_SETTLE_CNT0;
   localparam [40:0] slp1 = 41'h0b;
   localparam [40:0] slp2 = 41'h10;
   localparam [40:0] slp4 = 41'h1a;
   localparam [40:0] stl1 = 41'h0c;
   localparam [40:0] stl3 = 41'h16;
   lpcs_scheduler #(.SLEEP_CNT1(slp1), .SLEEP_CNT2(slp2), .SLEEP_CNT4(slp4),
      .SETTLE_CNT1(stl1), .SETTLE_CNT3(stl3)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .calTriggerPin(calTriggerPin), .coreCalDone(coreCalDone),
      .calibrateCore(calibrateCore), .coreSleep(coreSleep),
      .calTriggerLevel(calTriggerLevel), .gainTrim(gainTrim));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ------
   // Tasks
   // ------
   task chk(input [31:0] got, input [31:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   end
   endtask

   task xfer(input [11:0] a, input w, input [31:0] d);
      integer k;
   begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && k < 20)
      begin
         k = k + 1;
         @(posedge mclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(k < 20, 1);
   end
   endtask

   task wr(input [11:0] a, input [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task rd(input [11:0] a, input [31:0] x);
   begin
      xfer(a, 1'b0, 32'h0);
      chk(r, x);
      chk(e, 0);
   end
   endtask

   // Waits for coreSleep (c=0) or calibrateCore (c=1) to reach v
   task waitSig(input c, input v, output integer k);
   begin
      k = 0;
      while (((c ? calibrateCore : coreSleep) !== v) && k < 1300)
      begin
         @(posedge mclk);
         k = k + 1;
      end
   end
   endtask

   // One sleep, settle and calibrate round, lengths within two cycles
   task runCycle(input integer sl, input integer st);
   begin
      waitSig(0, 1, n);
      waitSig(0, 0, n);
      chk((n >= sl - 2 && n <= sl + 2) ? sl : n, sl);
      waitSig(1, 1, n);
      chk((n >= st - 2 && n <= st + 2) ? st : n, st);
      coreCalDone <= 1'b1;
      @(posedge mclk);
      coreCalDone <= 1'b0;
      @(posedge mclk);
      chk({calibrateCore, coreSleep}, 2'b01);
   end
   endtask

   task results;
   begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask

   // ------
   // Tests
   // ------
   initial
   begin
      miscompares = 0;
      checks = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      calTriggerPin = 1'b0;
      coreCalDone = 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(aSoft, 32'h1);
      rd(aLp, 32'h88);
      rd(aGain, 32'h0);
      rd(aSrc, 32'h0);
      rd(aBg, 32'h0);
      rd(aStat, 32'h10);
      chk(calTriggerLevel, 1);
      xfer(12'h010, 1'b0, 32'h0);
      chk(e, 1);
      chk(r, 0);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(aGain, 8'hff >> (3 * i));
         rd(aGain, 8'hff >> (3 * i));
         chk(gainTrim, 8'hff >> (3 * i));
      end
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(aSrc, i[2]);
         wr(aSoft, i[1]);
         calTriggerPin <= i[0];
         repeat (3) @(posedge mclk);
         chk(calTriggerLevel, i[2] ? i[0] : i[1]);
      end
      wr(aSrc, 0);
      wr(aSoft, 1);
      wr(aLp, 32'h89);
      repeat (20) @(posedge mclk);
      chk(coreSleep, 0);
      wr(aBg, 1);
      runCycle(slp4[31:0], stl1[31:0]);
      // Sleep codes 3, 5, 6 and 7 at full length: only check that the core stays asleep
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(aLp, 0);
         wr(aLp, {i[2:0], (i == 2) ? 2'h3 : i[1:0], 3'b001});
         case (i)
            0: runCycle(slp0[31:0], stl0[31:0]);
            1: runCycle(slp1[31:0], stl1[31:0]);
            2: runCycle(slp2[31:0], stl3[31:0]);
            4: runCycle(slp4[31:0], stl0[31:0]);
            default:
            begin
               waitSig(0, 1, n);
               repeat (1200) @(posedge mclk);
               chk(coreSleep, 1);
            end
         endcase
      end
      wr(aLp, 32'h88);
      repeat (2) @(posedge mclk);
      chk({calibrateCore, coreSleep}, 2'b00);
      wr(aLp, 32'hfb);
      waitSig(0, 1, n);
      repeat (60) @(posedge mclk);
      chk(coreSleep, 1);
      rd(aStat, 32'h35);
      wr(aSoft, 0);
      runCycle(1, stl3[31:0]);
      wr(aLp, 0);
      wr(aSoft, 1);
      wr(aLp, 32'h93);
      wr(aSoft, 0);
      waitSig(0, 0, n);
      repeat (1200) @(posedge mclk);
      chk({calibrateCore, coreSleep}, 2'b00);
      wr(aLp, 0);
      wr(aSrc, 1);
      calTriggerPin <= 1'b1;
      wr(aLp, 32'hfb);
      waitSig(0, 1, n);
      repeat (10) @(posedge mclk);
      chk(coreSleep, 1);
      calTriggerPin <= 1'b0;
      runCycle(1, stl3[31:0]);
      results;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares = miscompares + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      results;
   end
endmodule // tb_lpcs_scheduler
